// file: src/sacs_pkg.sv
// Shared constants for the successive-approximation conversion sequencer
package sacs_pkg;

  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int unsigned RESULT_BITS = 12;
  localparam logic [11:0] RESULT_RST  = 12'h000;
  localparam logic [11:0] MSB_TRIAL   = 12'h800;
  localparam logic [11:0] MIDSCALE_LO = 12'h7ff;
  localparam logic [11:0] MIDSCALE_HI = 12'h800;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ    = 25_000_000;
  localparam int unsigned DECIDE_DLY_NS  = 80;
  localparam int unsigned DECIDE_DLY_CYC =
    (DECIDE_DLY_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SYNC_PERIODS_MIN = 12;
  localparam int unsigned SYNC_PERIODS_MAX = 13;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ALIGN  = 4'b0010,
    ST_DECIDE = 4'b0100,
    ST_LOAD   = 4'b1000
  } sacs_state_e;

endpackage

// file: src/sacs_sequencer.sv
// Conversion sequencer core: start, bit decisions, result latch, bus drive
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Start clears approximation word, enables outputs
// - Start requests ignored during a conversion
// - Trial word settles MSB down to LSB
// - MSB decided after second falling clock edge
// - One further bit per later falling edge
// - Finished word copied into output latch
// - Wait first falling edge: 12-13 periods
// - Clock output is inverse of clock input
// - Unipolar result is straight binary
// - Bipolar result is offset binary
// - Start on low-going combined select and read
// - Active-low busy held through conversion
// - Starting read shows the previous result
module sacs_sequencer #(
  parameter int unsigned WIDTH    = 12,
  parameter int unsigned DLY_CYC  = sacs_pkg::DECIDE_DLY_CYC
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // Converter clock pins
  input  wire logic             convClkIn,
  output logic                  convClkOut,
  // Host strobes, active low
  input  wire logic             chipSelN,
  input  wire logic             readN,
  // Analog loop
  input  wire logic             compIn,
  output logic [WIDTH-1:0]      trialWord,
  // Result bus and status
  output logic [WIDTH-1:0]      resultBusO,
  output logic [WIDTH-1:0]      resultBusOe,
  output logic                  busyN,
  output logic                  rangeBipolar
);

  // ----------------------------------------
  // Strobe and clock-input edges
  // ----------------------------------------
  logic                   strobeLow;
  logic                   strobeLow_r;
  logic                   convClk_r;
  logic                   fallEdge;
  logic                   startReq;

  assign strobeLow  = ~chipSelN & ~readN;
  assign startReq   = strobeLow & ~strobeLow_r;
  assign fallEdge   = convClk_r & ~convClkIn;
  assign convClkOut = ~convClkIn;
  // Coding is identical for both ranges; bipolar reading is offset binary
  assign rangeBipolar = 1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobeLow_r <= 1'b0;
      convClk_r   <= 1'b0;
    end else if (clkEn) begin
      strobeLow_r <= strobeLow;
      convClk_r   <= convClkIn;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  sacs_pkg::sacs_state_e state_r;
  logic [WIDTH-1:0]       approx_register_r;
  logic [WIDTH-1:0]       bitPtr_r;
  logic [WIDTH-1:0]       latch_r;
  logic [7:0]             dlyCnt_r;
  logic                   pending_r;
  logic                   edgeSeen_r;

  assign trialWord = approx_register_r | bitPtr_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r           <= sacs_pkg::ST_IDLE;
      approx_register_r <= '0;
      bitPtr_r          <= '0;
      dlyCnt_r          <= 8'h00;
      pending_r         <= 1'b0;
      edgeSeen_r        <= 1'b0;
    end else if (clkEn) begin
      case (state_r)
        sacs_pkg::ST_IDLE: begin
          if (startReq) begin
            approx_register_r <= '0;
            bitPtr_r          <= '0;
            edgeSeen_r        <= 1'b0;
            state_r           <= sacs_pkg::ST_ALIGN;
          end
        end
        sacs_pkg::ST_ALIGN: begin
          // First falling edge only aligns; MSB trial set on the second
          if (fallEdge) begin
            if (edgeSeen_r) begin
              bitPtr_r <= {1'b1, {(WIDTH-1){1'b0}}};
              dlyCnt_r <= 8'(DLY_CYC);
              pending_r <= 1'b1;
              state_r  <= sacs_pkg::ST_DECIDE;
            end else begin
              edgeSeen_r <= 1'b1;
            end
          end
        end
        sacs_pkg::ST_DECIDE: begin
          if (pending_r) begin
            if (dlyCnt_r > 8'h01) begin
              dlyCnt_r <= dlyCnt_r - 8'h01;
            end else begin
              // Comparator high means trial exceeds input: drop the bit
              if (!compIn) begin
                approx_register_r <= approx_register_r | bitPtr_r;
              end
              pending_r <= 1'b0;
              if (bitPtr_r[0]) begin
                state_r <= sacs_pkg::ST_LOAD;
              end
            end
          end else if (fallEdge) begin
            bitPtr_r  <= bitPtr_r >> 1;
            dlyCnt_r  <= 8'(DLY_CYC);
            pending_r <= 1'b1;
          end
        end
        sacs_pkg::ST_LOAD: begin
          bitPtr_r <= '0;
          state_r  <= sacs_pkg::ST_IDLE;
        end
        default: state_r <= sacs_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Output latch, busy, bus drive
  // ----------------------------------------
  logic inConv;
  assign inConv = (state_r != sacs_pkg::ST_IDLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch_r <= '0;
    end else if (clkEn && state_r == sacs_pkg::ST_LOAD) begin
      latch_r <= approx_register_r;
    end
  end

  // Busy released together with the latch update; resultBusO shows the new data one cycle after the rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busyN <= 1'b1;
    end else if (clkEn) begin
      if (startReq && !inConv) begin
        busyN <= 1'b0;
      end else if (state_r == sacs_pkg::ST_LOAD) begin
        busyN <= 1'b1;
      end
    end
  end

  // Start-read drives old latch; a new start cannot occur while busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resultBusO  <= '0;
      resultBusOe <= '0;
    end else if (clkEn) begin
      resultBusO <= latch_r;
      if (startReq && !inConv) begin
        resultBusOe <= '1;
      end else if (!strobeLow && !inConv) begin
        resultBusOe <= '0;
      end else if (strobeLow) begin
        resultBusOe <= '1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Start and one-bit decision steps shared by the properties
  sequence s_start;
    clkEn && startReq && state_r == sacs_pkg::ST_IDLE;
  endsequence

  sequence s_trial_set;
    clkEn && fallEdge &&
      ((state_r == sacs_pkg::ST_ALIGN && edgeSeen_r) ||
       (state_r == sacs_pkg::ST_DECIDE && !pending_r));
  endsequence

  sequence s_decide_due;
    clkEn && state_r == sacs_pkg::ST_DECIDE && pending_r && dlyCnt_r <= 8'h01;
  endsequence

  // Load cycle, then idle with busy released
  sequence s_back_idle;
    (state_r == sacs_pkg::ST_LOAD) ##1 (state_r == sacs_pkg::ST_IDLE && busyN);
  endsequence

  property p_start_clears;
    @(posedge mclk) disable iff (rst)
    (clkEn && startReq && state_r == sacs_pkg::ST_IDLE) |=>
      approx_register_r == '0 && busyN == 1'b0 && resultBusOe == '1;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start did not clear");

  property p_no_restart;
    @(posedge mclk) disable iff (rst)
    (clkEn && startReq && state_r inside {sacs_pkg::ST_DECIDE, sacs_pkg::ST_LOAD}) |=>
      state_r != sacs_pkg::ST_ALIGN;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart during conversion");

  property p_clk_out;
    @(posedge mclk) disable iff (rst) convClkOut == ~convClkIn;
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock output not inverted");

  property p_busy_low;
    @(posedge mclk) disable iff (rst)
    inConv |-> busyN == 1'b0;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy high in conversion");

  property p_latch_load;
    @(posedge mclk) disable iff (rst)
    (clkEn && state_r == sacs_pkg::ST_LOAD) |=> latch_r == $past(approx_register_r) && busyN;
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_msb_first;
    @(posedge mclk) disable iff (rst)
    (clkEn && state_r == sacs_pkg::ST_ALIGN && fallEdge && edgeSeen_r) |=>
      bitPtr_r == {1'b1, {(WIDTH-1){1'b0}}};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB not first trial");

  property p_shift;
    @(posedge mclk) disable iff (rst)
    (clkEn && state_r == sacs_pkg::ST_DECIDE && !pending_r && fallEdge) |=>
      bitPtr_r == ($past(bitPtr_r) >> 1);
  endproperty
  a_shift: assert property (p_shift) else $error("bit pointer did not step");

  property p_release;
    @(posedge mclk) disable iff (rst)
    (clkEn && !strobeLow && !inConv && !startReq) |=> resultBusOe == '0;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  property p_start_seq;
    @(posedge mclk) disable iff (rst)
    s_start |=> state_r == sacs_pkg::ST_ALIGN;
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("start not taken");

  property p_trial_delay;
    @(posedge mclk) disable iff (rst)
    s_trial_set |=> pending_r && dlyCnt_r == 8'(DLY_CYC);
  endproperty
  a_trial_delay: assert property (p_trial_delay) else $error("delay not armed");

  property p_decide;
    @(posedge mclk) disable iff (rst)
    s_decide_due |=> !pending_r &&
      ((approx_register_r & $past(bitPtr_r)) == ($past(compIn) ? '0 : $past(bitPtr_r)));
  endproperty
  a_decide: assert property (p_decide) else $error("bit decision wrong");

  property p_lsb_load;
    @(posedge mclk) disable iff (rst)
    s_decide_due ##0 bitPtr_r[0] |=> s_back_idle;
  endproperty
  a_lsb_load: assert property (p_lsb_load) else $error("no load after LSB");

  property p_one_trial;
    @(posedge mclk) disable iff (rst)
    (state_r == sacs_pkg::ST_DECIDE) |->
      $onehot(bitPtr_r) && (approx_register_r & (bitPtr_r - 1'b1)) == '0;
  endproperty
  a_one_trial: assert property (p_one_trial) else $error("trial order broken");

  property p_latch_hold;
    @(posedge mclk) disable iff (rst)
    (state_r != sacs_pkg::ST_LOAD) |=> $stable(latch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed early");

  property p_drive_conv;
    @(posedge mclk) disable iff (rst)
    inConv |-> resultBusOe == '1;
  endproperty
  a_drive_conv: assert property (p_drive_conv) else $error("bus not driven");

  property p_idle_trial;
    @(posedge mclk) disable iff (rst)
    (state_r == sacs_pkg::ST_IDLE) |-> bitPtr_r == '0;
  endproperty
  a_idle_trial: assert property (p_idle_trial) else $error("trial bit left set");

endmodule
`default_nettype wire

// file: test/sacs_host_model.sv
// Host and comparator model facing the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sacs_host_model (
  // Clock
  input  wire logic        mclk,
  input  wire logic        convClkOut,
  // Analog loop
  input  wire logic [11:0] trialWord,
  input  wire logic [11:0] vin,
  output logic             compIn,
  // Host strobes
  output logic             chipSelN,
  output logic             readN
);
  // ----------------------------------------
  // Comparator: high drops the trial bit
  // ----------------------------------------
  assign compIn = trialWord > vin;

  initial begin
    chipSelN = 1'b1;
    readN    = 1'b1;
  end

  // ----------------------------------------
  // Strobe access
  // ----------------------------------------
  // Synced start lands on a falling clock-out edge for a fixed length
  task automatic strobe(input logic low, input bit sync);
    if (sync) begin
      @(negedge convClkOut);
    end else begin
      @(negedge mclk);
    end
    chipSelN = ~low;
    readN    = ~low;
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int P = 16;
  logic        mclk, rst, convClkIn, convClkOut, chipSelN, readN;
  logic        compIn, busyN, rangeBipolar;
  logic [11:0] trialWord, resultBusO, resultBusOe, vin;
  int          failCount, checked, cyc;

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Equal high and low time, P mclk cycles a period
  initial begin
    convClkIn = 1'b1;
    forever #(P*20) convClkIn = ~convClkIn;
  end

  sacs_sequencer i_dut (.mclk(mclk), .rst(rst), .clkEn(1'b1), .convClkIn(convClkIn),
    .convClkOut(convClkOut), .chipSelN(chipSelN), .readN(readN), .compIn(compIn),
    .trialWord(trialWord), .resultBusO(resultBusO), .resultBusOe(resultBusOe),
    .busyN(busyN), .rangeBipolar(rangeBipolar));
  sacs_host_model i_host (.mclk(mclk), .convClkOut(convClkOut), .trialWord(trialWord),
    .vin(vin), .compIn(compIn), .chipSelN(chipSelN), .readN(readN));

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (exp !== got) begin
      failCount++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // One conversion, optional mid-run restart attempt
  // ----------------------------------------
  task automatic convert(input logic [11:0] v, input bit sync, input bit retry);
    logic [11:0] old;
    int          t;
    int          lo;
    int          hi;
    old = resultBusO;
    lo  = sync ? 12*P + P/2 : 12*P;
    hi  = sync ? 12*P + P/2 + 8 : 13*P + 8;
    vin = v;
    i_host.strobe(1'b1, sync);
    repeat (2) @(negedge mclk);
    t = 2;
    check("clkOut", {11'h000, ~convClkIn}, convClkOut);
    check("trialClr", 12'h000, trialWord);
    check("busyN", 12'h000, busyN);
    check("oe", 12'hfff, resultBusOe);
    check("oldData", old, resultBusO);
    while (busyN !== 1'b1 && t < 2000) begin
      if (retry && (t == 60 || t == 62)) begin
        i_host.strobe(t == 62, 1'b0);
      end else begin
        @(negedge mclk);
      end
      t++;
    end
    check("convTime", 12'h001, (t >= lo && t <= hi));
    @(negedge mclk);
    check("result", v, resultBusO);
    check("trialEnd", v, trialWord);
    // Release and leave spacing before the next read
    i_host.strobe(1'b0, 1'b0);
    repeat (2) @(negedge mclk);
    check("oeOff", 12'h000, resultBusOe);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failCount++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset at power-up, or in the middle of a conversion with a used latch
  task automatic test_reset(input bit midRun);
    if (midRun) begin
      i_host.strobe(1'b1, 1'b0);
      repeat (20) @(negedge mclk);
      check("busyMid", 12'h000, busyN);
    end
    rst = 1'b1;
    // Strobes high before release, else the release itself starts a conversion
    i_host.strobe(1'b0, 1'b0);
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    check("busyRst", 12'h001, busyN);
    check("oeRst", 12'h000, resultBusOe);
    check("busRst", 12'h000, resultBusO);
    check("trialRst", 12'h000, trialWord);
    check("range", 12'h000, rangeBipolar);
    repeat (2) @(negedge mclk);
    check("busyIdle", 12'h001, busyN);
    check("oeIdle", 12'h000, resultBusOe);
  endtask

  task automatic test_slow_read;
    convert(12'ha5c, 1'b0, 1'b0);
  endtask

  // Strobes raised and dropped again while converting
  task automatic test_restart_ignored;
    convert(12'h7ff, 1'b0, 1'b1);
  endtask

  task automatic test_sync_start;
    convert(12'h800, 1'b1, 1'b0);
  endtask

  // Idle gap moves the start to another clock phase
  task automatic test_full_scale;
    repeat (5) @(negedge mclk);
    convert(12'hfff, 1'b0, 1'b0);
  endtask

  // First read after a reset shows the cleared latch
  task automatic test_after_reset;
    convert(12'h3c3, 1'b0, 1'b0);
  endtask

  initial begin
    vin = 12'h000;
    test_reset(1'b0);
    test_slow_read();
    test_restart_ignored();
    test_sync_start();
    test_full_scale();
    test_reset(1'b1);
    test_after_reset();
    finish_test();
  end
endmodule
`default_nettype wire
